// ### design/fbsw_slave.sv
// fieldbus slave parameter lock, response delay, watchdog, groups, freeze and sync
//
// Contract
// - locked mode refuses parameters from other masters; unlocked holds no lock.
// - overwrite mode accepts a new response delay from others, and nothing else.
// - reply waits at least the response delay, 11 to 1023 bit times.
// - enabled watchdog returns slave to unconfigured when exchange period exceeds it.
// - slave holds any combination of groups 1 to 8.
// - freeze and sync act only when slave belongs to an addressed group.
// - freeze mode latches inputs on freeze command; off by default.
// - sync mode holds outputs, applies them on sync command; off by default.
// - watchdog timebase 10 ms, or 1 ms with fine timebase select.
`timescale 1ns/1ps
module fbsw_slave (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// station configuration
	input wire logic [fbsw_pkg::ADDR_W-1:0] station_address,
	// request frame from the link
	input wire logic req_valid,
	input wire logic [fbsw_pkg::ADDR_W-1:0] req_dest,
	input wire logic [fbsw_pkg::MASTER_W-1:0] req_master,
	input wire logic bit_tick,
	// parameter telegram fields, taken with req_param
	input wire logic req_param,
	input wire logic [1:0] prm_lock_mode,
	input wire logic [fbsw_pkg::DELAY_W-1:0] prm_min_response_delay,
	input wire logic prm_wdog_enable,
	input wire logic [fbsw_pkg::WDOG_W-1:0] prm_wdog_value,
	input wire logic prm_fine_timebase_select,
	input wire logic [fbsw_pkg::GROUP_W-1:0] prm_groups,
	input wire logic prm_freeze_enable,
	input wire logic prm_sync_enable,
	// data exchange request
	input wire logic req_exchange,
	input wire logic [fbsw_pkg::DATA_W-1:0] req_out_data,
	// global control command
	input wire logic req_control,
	input wire logic [fbsw_pkg::GROUP_W-1:0] ctl_groups,
	input wire logic ctl_freeze,
	input wire logic ctl_unfreeze,
	input wire logic ctl_sync,
	input wire logic ctl_unsync,
	// process side
	input wire logic [fbsw_pkg::DATA_W-1:0] process_inputs,
	output logic [fbsw_pkg::DATA_W-1:0] process_outputs,
	output logic [fbsw_pkg::DATA_W-1:0] reply_inputs,
	// status
	output logic reply_go,
	output logic param_refused,
	output logic configured,
	output logic exchanging,
	output logic wdog_expired,
	output logic locked,
	output logic [fbsw_pkg::MASTER_W-1:0] lock_owner,
	output logic [fbsw_pkg::DELAY_W-1:0] min_response_delay,
	output logic [fbsw_pkg::GROUP_W-1:0] group_set,
	output logic freeze_active,
	output logic sync_active
);
	// ------------------------------------------------------------
	// request qualification
	// ------------------------------------------------------------
	logic own_req;
	logic in_group;
	logic param_ok;
	logic full_param;
	logic [fbsw_pkg::DELAY_W-1:0] delay_clamped;
	fbsw_pkg::fbsw_state_t state, next_state;

	assign own_req = req_valid && (req_dest == station_address);
	assign in_group = |(ctl_groups & group_set);
	// a foreign master may only change the response delay, and only in overwrite mode
	assign full_param = !locked || (req_master == lock_owner);
	assign param_ok = full_param || (prm_lock_mode == fbsw_pkg::LOCK_OVERWRITE);
	assign delay_clamped = (prm_min_response_delay < fbsw_pkg::DELAY_MIN) ?
		fbsw_pkg::DELAY_MIN : prm_min_response_delay;

	// ------------------------------------------------------------
	// watchdog timebase and counter
	// ------------------------------------------------------------
	logic wdog_enable;
	logic fine_timebase_select;
	logic [fbsw_pkg::WDOG_W-1:0] wdog_value;
	logic [fbsw_pkg::TICK_W-1:0] tick_count, next_tick_count;
	logic base_tick;
	logic wdog_load;
	logic wdog_zero;
	logic wdog_trip;

	// base_tick only comes from a registered counter so the watchdog steps cleanly
	always_comb begin
		next_tick_count = tick_count + {{(fbsw_pkg::TICK_W-1){1'b0}}, 1'b1};
		if (base_tick || own_req) begin
			next_tick_count = '0;
		end
	end

	always_comb begin
		if (fine_timebase_select) begin
			base_tick = (tick_count == fbsw_pkg::TICK_W'(fbsw_pkg::FINE_TICK_CYCLES - 1));
		end else begin
			base_tick = (tick_count == fbsw_pkg::TICK_W'(fbsw_pkg::COARSE_TICK_CYCLES - 1));
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_count <= '0;
		end else begin
			tick_count <= next_tick_count;
		end
	end

	assign wdog_load = own_req;

	fbsw_counter #(
		.WIDTH(fbsw_pkg::WDOG_W)
	) u_wdog (
		.clock(clock),
		.rst_n(rst_n),
		.load(wdog_load),
		// an accepted full parameter frame arms the timer with the value it carries, not the old one
		.load_value(next_wdog_value),
		.step(base_tick),
		.count(),
		.zero(wdog_zero)
	);

	// timer reaching zero while armed means no own request for the watchdog time
	assign wdog_trip = wdog_enable && wdog_zero && !own_req &&
		(state != fbsw_pkg::FBSW_UNCONFIG);

	// ------------------------------------------------------------
	// response delay in bit times
	// ------------------------------------------------------------
	fbsw_pkg::fbsw_resp_t resp, next_resp;
	logic resp_load;
	logic resp_zero;
	logic next_reply_go;

	assign resp_load = own_req && resp == fbsw_pkg::FBSW_R_IDLE;

	fbsw_counter #(
		.WIDTH(fbsw_pkg::DELAY_W)
	) u_resp (
		.clock(clock),
		.rst_n(rst_n),
		.load(resp_load),
		.load_value(min_response_delay),
		.step(bit_tick),
		.count(),
		.zero(resp_zero)
	);

	always_comb begin
		next_resp = resp;
		next_reply_go = 1'b0;
		unique case (resp)
			fbsw_pkg::FBSW_R_IDLE: begin
				if (resp_load) begin
					next_resp = fbsw_pkg::FBSW_R_WAIT;
				end
			end
			fbsw_pkg::FBSW_R_WAIT: begin
				if (resp_zero) begin
					next_resp = fbsw_pkg::FBSW_R_IDLE;
					next_reply_go = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			resp <= fbsw_pkg::FBSW_R_IDLE;
			reply_go <= 1'b0;
		end else begin
			resp <= next_resp;
			reply_go <= next_reply_go;
		end
	end

	// ------------------------------------------------------------
	// parameters, lock and slave state
	// ------------------------------------------------------------
	logic next_wdog_enable, next_fine, next_locked, next_refused;
	logic next_freeze_enable, next_sync_enable, freeze_enable, sync_enable;
	logic [fbsw_pkg::WDOG_W-1:0] next_wdog_value;
	logic [fbsw_pkg::MASTER_W-1:0] next_lock_owner;
	logic [fbsw_pkg::DELAY_W-1:0] next_delay;
	logic [fbsw_pkg::GROUP_W-1:0] next_group_set;

	always_comb begin
		next_state = state;
		next_wdog_enable = wdog_enable;
		next_fine = fine_timebase_select;
		next_wdog_value = wdog_value;
		next_locked = locked;
		next_lock_owner = lock_owner;
		next_delay = min_response_delay;
		next_group_set = group_set;
		next_freeze_enable = freeze_enable;
		next_sync_enable = sync_enable;
		next_refused = 1'b0;
		if (wdog_trip) begin
			// back to power-up values except wdog_value; lock released so any master may rebuild
			next_state = fbsw_pkg::FBSW_UNCONFIG;
			next_wdog_enable = 1'b0;
			next_fine = 1'b0;
			next_locked = 1'b0;
			next_lock_owner = '0;
			next_delay = fbsw_pkg::DELAY_DEFAULT;
			next_group_set = fbsw_pkg::GROUP_NONE;
			next_freeze_enable = 1'b0;
			next_sync_enable = 1'b0;
		end else if (own_req && req_param) begin
			if (!param_ok) begin
				next_refused = 1'b1;
			end else begin
				next_delay = delay_clamped;
				if (full_param) begin
					next_locked = (prm_lock_mode == fbsw_pkg::LOCK_LOCKED);
					next_lock_owner = req_master;
					next_wdog_enable = prm_wdog_enable;
					next_fine = prm_fine_timebase_select;
					next_wdog_value = (prm_wdog_value == '0) ? fbsw_pkg::WDOG_ONE :
						prm_wdog_value;
					next_group_set = prm_groups;
					next_freeze_enable = prm_freeze_enable;
					next_sync_enable = prm_sync_enable;
					next_state = fbsw_pkg::FBSW_CONFIG;
				end
			end
		end else if (own_req && req_exchange && state != fbsw_pkg::FBSW_UNCONFIG) begin
			next_state = fbsw_pkg::FBSW_EXCHANGE;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= fbsw_pkg::FBSW_UNCONFIG;
			wdog_enable <= 1'b0;
			fine_timebase_select <= 1'b0;
			wdog_value <= fbsw_pkg::WDOG_ONE;
			locked <= 1'b0;
			lock_owner <= '0;
			min_response_delay <= fbsw_pkg::DELAY_DEFAULT;
			group_set <= fbsw_pkg::GROUP_NONE;
			freeze_enable <= 1'b0;
			sync_enable <= 1'b0;
			param_refused <= 1'b0;
		end else begin
			state <= next_state;
			wdog_enable <= next_wdog_enable;
			fine_timebase_select <= next_fine;
			wdog_value <= next_wdog_value;
			locked <= next_locked;
			lock_owner <= next_lock_owner;
			min_response_delay <= next_delay;
			group_set <= next_group_set;
			freeze_enable <= next_freeze_enable;
			sync_enable <= next_sync_enable;
			param_refused <= next_refused;
		end
	end

	// ------------------------------------------------------------
	// freeze, sync and data paths
	// ------------------------------------------------------------
	logic next_freeze_active, next_sync_active;
	logic [fbsw_pkg::DATA_W-1:0] next_reply_inputs, next_outputs, held_out, next_held_out;
	logic ctl_hit;

	// control commands are broadcast, so the address check is skipped here
	assign ctl_hit = req_valid && req_control && in_group &&
		(state == fbsw_pkg::FBSW_EXCHANGE);

	always_comb begin
		next_freeze_active = freeze_active;
		next_sync_active = sync_active;
		next_reply_inputs = freeze_active ? reply_inputs : process_inputs;
		next_held_out = held_out;
		next_outputs = process_outputs;
		if (ctl_hit && freeze_enable) begin
			if (ctl_freeze) begin
				next_freeze_active = 1'b1;
				next_reply_inputs = process_inputs;
			end else if (ctl_unfreeze) begin
				next_freeze_active = 1'b0;
			end
		end
		if (own_req && req_exchange && state != fbsw_pkg::FBSW_UNCONFIG) begin
			next_held_out = req_out_data;
			if (!sync_active) begin
				next_outputs = req_out_data;
			end
		end
		if (ctl_hit && sync_enable) begin
			if (ctl_sync) begin
				next_sync_active = 1'b1;
				next_outputs = held_out;
			end else if (ctl_unsync) begin
				next_sync_active = 1'b0;
				next_outputs = held_out;
			end
		end
		if (wdog_trip) begin
			next_freeze_active = 1'b0;
			next_sync_active = 1'b0;
			next_outputs = fbsw_pkg::DATA_ZERO;
			next_held_out = fbsw_pkg::DATA_ZERO;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			freeze_active <= 1'b0;
			sync_active <= 1'b0;
			reply_inputs <= fbsw_pkg::DATA_ZERO;
			held_out <= fbsw_pkg::DATA_ZERO;
			process_outputs <= fbsw_pkg::DATA_ZERO;
			configured <= 1'b0;
			exchanging <= 1'b0;
			wdog_expired <= 1'b0;
		end else begin
			freeze_active <= next_freeze_active;
			sync_active <= next_sync_active;
			reply_inputs <= next_reply_inputs;
			held_out <= next_held_out;
			process_outputs <= next_outputs;
			configured <= (next_state != fbsw_pkg::FBSW_UNCONFIG);
			exchanging <= (next_state == fbsw_pkg::FBSW_EXCHANGE);
			wdog_expired <= wdog_trip;
		end
	end
endmodule

// ### design/fbsw_pkg.sv
// package: constants and types for the fieldbus slave parameter/watchdog block
package fbsw_pkg;
	// ------------------------------------------------------------
	// clock and timebases
	// ------------------------------------------------------------
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int FINE_TICK_US = 1000;
	localparam int COARSE_TICK_US = 10000;
	// scaled as ns over ns so the coarse product stays inside a 32-bit int
	localparam int FINE_TICK_CYCLES = (FINE_TICK_US * 1000) / (CLOCK_PERIOD_PS / 1000);
	localparam int COARSE_TICK_CYCLES = (COARSE_TICK_US * 1000) / (CLOCK_PERIOD_PS / 1000);
	localparam int TICK_W = 22;

	// ------------------------------------------------------------
	// response delay in bit times
	// ------------------------------------------------------------
	localparam int DELAY_W = 10;
	localparam logic [DELAY_W-1:0] DELAY_MIN = 10'h00B;
	localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h3FF;
	localparam logic [DELAY_W-1:0] DELAY_DEFAULT = 10'h00B;

	// ------------------------------------------------------------
	// other field widths and reset values
	// ------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int MASTER_W = 7;
	localparam int WDOG_W = 16;
	localparam int GROUP_W = 8;
	localparam int DATA_W = 32;
	localparam logic [GROUP_W-1:0] GROUP_NONE = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
	localparam logic [WDOG_W-1:0] WDOG_ONE = 16'h0001;

	// ------------------------------------------------------------
	// lock setting
	// ------------------------------------------------------------
	localparam logic [1:0] LOCK_UNLOCKED = 2'h0;
	localparam logic [1:0] LOCK_LOCKED = 2'h1;
	localparam logic [1:0] LOCK_OVERWRITE = 2'h2;

	// ------------------------------------------------------------
	// slave states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FBSW_UNCONFIG = 3'h1,
		FBSW_CONFIG = 3'h2,
		FBSW_EXCHANGE = 3'h4
	} fbsw_state_t;

	typedef enum logic [1:0] {
		FBSW_R_IDLE = 2'h1,
		FBSW_R_WAIT = 2'h2
	} fbsw_resp_t;
endpackage

// ### design/fbsw_counter.sv
// load-and-count-down timer used for bit-time and watchdog counting
`timescale 1ns/1ps
module fbsw_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic step,
	// status
	output logic [WIDTH-1:0] count,
	output logic zero
);
	logic [WIDTH-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_value;
		end else if (step && count != '0) begin
			next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign zero = (count == '0);
endmodule

// ### verif/fbsw_properties.sv
// checker: timing and state relations at the slave's ports
`timescale 1ns/1ps
module fbsw_properties (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// request side
	input wire logic [6:0] station_address,
	input wire logic req_valid,
	input wire logic [6:0] req_dest,
	input wire logic [6:0] req_master,
	input wire logic bit_tick,
	input wire logic req_param,
	input wire logic [1:0] prm_lock_mode,
	input wire logic req_exchange,
	input wire logic [31:0] req_out_data,
	input wire logic req_control,
	input wire logic [7:0] ctl_groups,
	input wire logic ctl_freeze,
	// slave side
	input wire logic [31:0] process_outputs,
	input wire logic [31:0] reply_inputs,
	input wire logic reply_go,
	input wire logic param_refused,
	input wire logic configured,
	input wire logic locked,
	input wire logic [6:0] lock_owner,
	input wire logic [9:0] min_response_delay,
	input wire logic [7:0] group_set,
	input wire logic freeze_active,
	input wire logic sync_active
);
	logic own;
	logic pend;
	logic [10:0] cnt;
	logic [9:0] cap;
	assign own = req_valid && !req_control && req_dest == station_address;
	// bit ticks since the request that armed the reply; saturates so it never wraps
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			cnt <= 11'h000;
			cap <= 10'h000;
		end else if (own && !pend) begin
			pend <= 1'b1;
			cnt <= 11'h000;
			cap <= min_response_delay;
		end else begin
			if (reply_go) pend <= 1'b0;
			if (bit_tick && cnt != 11'h7FF) cnt <= cnt + 11'h001;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_refuse_locked: assert property (
		own && req_param && locked && req_master != lock_owner && prm_lock_mode != 2'h2
		|=> param_refused) else $error("foreign parameters not refused");
	chk_refuse_cause: assert property (
		param_refused |-> $past(own && req_param && locked))
		else $error("refusal without a locked parameter request");
	chk_owner_set: assert property (
		$rose(locked) |-> lock_owner == $past(req_master)) else $error("wrong lock owner");
	chk_delay_floor: assert property (
		min_response_delay >= 10'h00B) else $error("response delay below floor");
	chk_reply_spacing: assert property (
		reply_go && pend |-> cnt >= {1'b0, cap}) else $error("reply came too early");
	chk_freeze_cause: assert property (
		$rose(freeze_active)
		|-> $past(req_valid && req_control && ctl_freeze && |(ctl_groups & group_set)))
		else $error("freeze without matching group command");
	chk_freeze_hold: assert property (
		freeze_active && $past(freeze_active) && !$past(req_valid && req_control)
		|-> $stable(reply_inputs)) else $error("frozen inputs moved");
	chk_sync_hold: assert property (
		sync_active && $past(sync_active) && !$past(req_valid && req_control)
		|-> $stable(process_outputs)) else $error("held outputs moved");
	chk_exch_out: assert property (
		own && req_exchange && configured && !sync_active
		|=> process_outputs == $past(req_out_data)) else $error("outputs not applied");
	cover property (param_refused);
	cover property ($rose(freeze_active));
	cover property (reply_go && pend);
endmodule

// ### verif/fbsw_master.sv
// master side model: request frames, bit tick and the host data block
`timescale 1ns/1ps
module fbsw_master #(
	parameter int GAP = 40,
	parameter logic [6:0] STATION = 7'h02,
	parameter bit BIG = 1'b1
) (
	// clock
	input wire logic clock,
	// request frame
	output logic req_valid,
	output logic [6:0] req_dest,
	output logic [6:0] req_master,
	output logic bit_tick,
	output logic req_param,
	output logic [1:0] prm_lock_mode,
	output logic [9:0] prm_min_response_delay,
	output logic prm_wdog_enable,
	output logic [15:0] prm_wdog_value,
	output logic prm_fine_timebase_select,
	output logic [7:0] prm_groups,
	output logic prm_freeze_enable,
	output logic prm_sync_enable,
	output logic req_exchange,
	output logic [31:0] req_out_data,
	output logic req_control,
	output logic [7:0] ctl_groups,
	output logic ctl_freeze,
	output logic ctl_unfreeze,
	output logic ctl_sync,
	output logic ctl_unsync,
	// reply
	input wire logic reply_go,
	input wire logic [31:0] reply_inputs
);
	logic [1:0] tdiv = 2'h0;
	logic [31:0] host_word;
	initial begin
		{req_valid, req_param, req_exchange, req_control} = 4'h0;
		{ctl_freeze, ctl_unfreeze, ctl_sync, ctl_unsync} = 4'h0;
		{prm_freeze_enable, prm_sync_enable, prm_wdog_enable} = 3'h1;
		prm_fine_timebase_select = 1'b1;
		prm_wdog_value = 16'h0064;
		{req_dest, req_master, prm_lock_mode, prm_min_response_delay} = 26'h0;
		{prm_groups, ctl_groups, req_out_data} = 48'h0;
	end
	always @(posedge clock) begin
		tdiv <= tdiv + 2'h1;
		bit_tick <= (tdiv == 2'h3);
	end
	// host block keeps the first byte in the top lane
	always @(posedge clock) begin
		if (reply_go === 1'b1) begin
			host_word <= BIG ? reply_inputs : {reply_inputs[7:0], reply_inputs[15:8],
				reply_inputs[23:16], reply_inputs[31:24]};
		end
	end
	// released dest, data and group fields are inverted so stale values are never mistaken for live ones; strobes and commands are cleared
	task automatic frame(input logic [6:0] dest, input logic [2:0] kind);
		req_valid <= 1'b1;
		req_dest <= dest;
		{req_param, req_exchange, req_control} <= kind;
		@(posedge clock);
		req_valid <= 1'b0;
		{req_param, req_exchange, req_control} <= 3'h0;
		{ctl_freeze, ctl_unfreeze, ctl_sync, ctl_unsync} <= 4'h0;
		req_dest <= ~dest;
		req_out_data <= ~req_out_data;
		ctl_groups <= ~ctl_groups;
		repeat (GAP) @(posedge clock);
	endtask
	task automatic param(input logic [6:0] m, input logic [1:0] lk, input logic [9:0] d,
		input logic [7:0] g, input logic [1:0] fs);
		@(posedge clock);
		req_master <= m;
		prm_lock_mode <= lk;
		prm_min_response_delay <= d;
		prm_groups <= g;
		{prm_freeze_enable, prm_sync_enable} <= fs;
		frame(STATION, 3'h4);
	endtask
	task automatic exch(input logic [31:0] data);
		@(posedge clock);
		req_out_data <= data;
		frame(STATION, 3'h2);
	endtask
	task automatic ctl(input logic [7:0] g, input logic [3:0] cmd);
		@(posedge clock);
		ctl_groups <= g;
		{ctl_freeze, ctl_unfreeze, ctl_sync, ctl_unsync} <= cmd;
		frame(7'h7F, 3'h1);
	endtask
endmodule

// ### verif/testbench.sv
// testbench: drives the slave through the master model and checks its state
`timescale 1ns/1ps
`define CHECK(nm, e, g) check_val(nm, 32'(e), 32'(g), ((g) === (e)))
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] station_address = 7'h02;
	logic [31:0] process_inputs = 32'h00000000;
	int failures = 0;
	int n_checks = 0;
	int n_refused = 0;
	int n_reply = 0;
	logic req_valid, bit_tick, req_param, prm_wdog_enable, prm_fine_timebase_select;
	logic prm_freeze_enable, prm_sync_enable, req_exchange, req_control;
	logic ctl_freeze, ctl_unfreeze, ctl_sync, ctl_unsync;
	logic [6:0] req_dest, req_master, lock_owner;
	logic [1:0] prm_lock_mode;
	logic [9:0] prm_min_response_delay, min_response_delay;
	logic [15:0] prm_wdog_value;
	logic [7:0] prm_groups, ctl_groups, group_set;
	logic [31:0] req_out_data, process_outputs, reply_inputs;
	logic reply_go, param_refused, configured, exchanging, wdog_expired, locked;
	logic freeze_active, sync_active;
	always #2 clock = ~clock;
	fbsw_slave fbsw_slave_i (.*);
	fbsw_master fbsw_master_i (.*);
	always @(posedge clock) begin
		if (param_refused === 1'b1) n_refused++;
		if (reply_go === 1'b1) n_reply++;
	end
	task automatic check_val(input string nm, input logic [31:0] e, g, input bit ok);
		n_checks++;
		if (!ok) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		`CHECK("delay", 10'h00B, min_response_delay);
		`CHECK("freeze", 1'b0, freeze_active);
		`CHECK("sync", 1'b0, sync_active);
		fbsw_master_i.exch(32'hA5A5A5A5);
		`CHECK("unconf_out", 32'h00000000, process_outputs);
		fbsw_master_i.param(7'h01, fbsw_pkg::LOCK_LOCKED, 10'h005, 8'h05, 2'h3);
		`CHECK("configured", 1'b1, configured);
		`CHECK("locked", 1'b1, locked);
		`CHECK("owner", 7'h01, lock_owner);
		`CHECK("clamp", 10'h00B, min_response_delay);
		`CHECK("groups", 8'h05, group_set);
		fbsw_master_i.param(7'h03, fbsw_pkg::LOCK_LOCKED, 10'h030, 8'hFF, 2'h3);
		`CHECK("refused", 1, n_refused);
		`CHECK("kept_groups", 8'h05, group_set);
		fbsw_master_i.param(7'h03, fbsw_pkg::LOCK_OVERWRITE, 10'h3FF, 8'hFF, 2'h3);
		`CHECK("overwrite", 10'h3FF, min_response_delay);
		`CHECK("ow_owner", 7'h01, lock_owner);
		fbsw_master_i.exch(32'h12345678);
		`CHECK("exchanging", 1'b1, exchanging);
		`CHECK("outputs", 32'h12345678, process_outputs);
		process_inputs <= 32'hCAFE0001;
		fbsw_master_i.ctl(8'h02, 4'h8);
		`CHECK("no_group", 1'b0, freeze_active);
		fbsw_master_i.ctl(8'h04, 4'h8);
		`CHECK("frozen", 1'b1, freeze_active);
		process_inputs <= 32'h0BAD0002;
		repeat (8) @(posedge clock);
		`CHECK("held_in", 32'hCAFE0001, reply_inputs);
		fbsw_master_i.ctl(8'h01, 4'h4);
		`CHECK("live_in", 32'h0BAD0002, reply_inputs);
		fbsw_master_i.ctl(8'h01, 4'h2);
		`CHECK("synced", 1'b1, sync_active);
		fbsw_master_i.exch(32'h55AA55AA);
		`CHECK("held_out", 32'h12345678, process_outputs);
		fbsw_master_i.ctl(8'h01, 4'h1);
		`CHECK("unsynced", 1'b0, sync_active);
		fbsw_master_i.param(7'h01, fbsw_pkg::LOCK_UNLOCKED, 10'h00B, 8'h05, 2'h0);
		`CHECK("unlocked", 1'b0, locked);
		repeat (4200) @(posedge clock);
		`CHECK("replies", 1'b1, n_reply > 0);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		finish_test();
	end
endmodule
bind fbsw_slave fbsw_properties fbsw_properties_i (.*);
